// file: rtl/spmc_defs.svh
// Purpose: timing counts, mode codes and reset values for the sensor power-mode control
// Assumes: 40 MHz core clock (25 ns)
// Notes: times are in ns; cycle counts derive from them
`ifndef SPMC_DEFS_SVH
`define SPMC_DEFS_SVH

`define SPMC_CLK_PERIOD_NS 25
`define SPMC_ACT_INIT_NS 10000
`define SPMC_STBY_INIT_NS 35000
`define SPMC_STBY_ENTRY_NS 5000
`define SPMC_SLEEP_EXIT_NS 50000
`define SPMC_ACT_INIT_CYC ((`SPMC_ACT_INIT_NS + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)
`define SPMC_STBY_INIT_CYC ((`SPMC_STBY_INIT_NS + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)
`define SPMC_STBY_ENTRY_CYC ((`SPMC_STBY_ENTRY_NS + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)
`define SPMC_SLEEP_EXIT_CYC ((`SPMC_SLEEP_EXIT_NS + `SPMC_CLK_PERIOD_NS - 1) / `SPMC_CLK_PERIOD_NS)
`define SPMC_MS_CYC 40000

`define SPMC_MODE_CONFIG 3'h0
`define SPMC_MODE_STANDBY 3'h1
`define SPMC_MODE_ACT_CONT 3'h2
`define SPMC_MODE_ACT_TRIG 3'h3
`define SPMC_MODE_WAKE_SLEEP 3'h4
`define SPMC_MODE_SLEEP 3'h5
`define SPMC_MODE_DEEP_SLEEP 3'h6

`define SPMC_TRIG_SERIAL 2'h0
`define SPMC_TRIG_ALERT 2'h1

`define SPMC_ALERT_ON_DONE 1'h0
`define SPMC_ALERT_ON_THRESH 1'h1

`define SPMC_CFG_RESET 17'h00000

`endif

// file: rtl/spmc_pkg.sv
// Purpose: shared types for the sensor power-mode control
// Assumes: nothing
// Notes: configuration bundle is cleared by deep sleep
package spmc_pkg;

	typedef enum logic [2:0] {
		SPMC_CONFIG,
		SPMC_ENTER_STBY,
		SPMC_STANDBY,
		SPMC_INIT,
		SPMC_CONVERT,
		SPMC_SLEEPING,
		SPMC_WAKE_EXIT
	} spmc_state_type;

	typedef struct packed {
		logic [3:0] axis_enable_set;
		logic [2:0] averaging_select;
		logic [1:0] self_check_schedule;
		logic self_check_enable;
		logic [1:0] trigger_source;
		logic alert_select;
		logic [3:0] wake_interval_sel;
	} spmc_cfg_type;

endpackage

// file: rtl/spmc_delay.sv
// Purpose: down-counter that times mode-entry and initialization delays
// Assumes: load and run come from the same clock domain
// Notes: done is a one-cycle pulse once the count has run down to one
`timescale 1ns/1ps
module spmc_delay #(
	parameter int WIDTH = 26
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// control
	input wire logic load,
	input wire logic [WIDTH-1:0] count,
	// status
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] cnt_q;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			busy <= 1'b0;
			done <= 1'b0;
		end else if (clk_en) begin
			done <= 1'b0;
			if (load) begin
				cnt_q <= count;
				busy <= 1'b1;
			end else if (busy) begin
				if (cnt_q <= 1) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end
endmodule

// file: rtl/spmc_top.sv
// Purpose: operating-mode sequencer of a three-axis magnetic sensor
// Assumes: serial framing decoded elsewhere; conversion engine reports done
// Notes: delays counted on the core oscillator clock
// Function
// - power-up enters configuration mode
// - mode-select field chooses operating mode
// - active conversion starts after 10 us
// - standby trigger starts after 35 us
// - configuration trigger adds standby entry time
// - nine wake intervals selectable
// - deep sleep never starts conversion
// - continuous or triggered by mode field
// - react only to selected trigger source
// - conversion length set by conversion settings
// - standby keeps support circuitry powered
// - configuration allows register access
// - configuration also accepts triggered conversion
// - sleep keeps configuration and results
// - wake from sleep by serial or alert
// - sleep exit returns to configuration
// - wake cycle converts selected channels
// - optional alert pulse per wake conversion
// - alternative alert on threshold exceed
// - controller may wake anytime and read
// - deep sleep restores factory configuration
// - deep sleep exit reaches configuration
`timescale 1ns/1ps
`include "spmc_defs.svh"
module spmc_top import spmc_pkg::*; #(
	parameter int CNT_W = 26,
	parameter int STBY_ENTRY_CYC = `SPMC_STBY_ENTRY_CYC,
	parameter int SLEEP_EXIT_CYC = `SPMC_SLEEP_EXIT_CYC,
	parameter int MS_CYC = `SPMC_MS_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic clk_en,
	// controller side
	input wire logic [2:0] mode_select,
	input wire logic mode_write,
	input wire spmc_cfg_type cfg_in,
	input wire logic cfg_write,
	input wire logic serial_activity,
	input wire logic serial_trigger,
	// alert pin, open drain, active low
	input wire logic alert_n_in,
	output logic alert_n_out,
	output logic alert_n_oe,
	// conversion engine
	input wire logic conv_done,
	input wire logic thresh_hit,
	output logic conv_start,
	output logic [CNT_W-1:0] conv_cycles,
	output logic results_clear,
	// status
	output logic [2:0] mode_q,
	output logic support_on,
	output logic reg_access,
	output spmc_cfg_type cfg_q
);
	localparam int ACT_CYC = `SPMC_ACT_INIT_CYC;
	localparam int STBY_CYC = `SPMC_STBY_INIT_CYC;

	spmc_state_type state_q;
	logic alert_s1_q, alert_s2_q, alert_s3_q;
	logic dly_load;
	logic [CNT_W-1:0] dly_count;
	logic dly_busy, dly_done;
	logic [CNT_W-1:0] wake_cnt_q;
	logic trig_hit, alert_fall, wake_tick;
	logic [2:0] own_drive_q;

	function automatic logic [CNT_W-1:0] wake_ms(input logic [3:0] sel);
		case (sel)
			4'h0: wake_ms = CNT_W'(1);
			4'h1: wake_ms = CNT_W'(5);
			4'h2: wake_ms = CNT_W'(10);
			4'h3: wake_ms = CNT_W'(15);
			4'h4: wake_ms = CNT_W'(20);
			4'h5: wake_ms = CNT_W'(30);
			4'h6: wake_ms = CNT_W'(100);
			4'h7: wake_ms = CNT_W'(500);
			default: wake_ms = CNT_W'(1000);
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] conv_len(input spmc_cfg_type c);
		logic [3:0] n;
		n = 4'(c.axis_enable_set[0]) + 4'(c.axis_enable_set[1])
			+ 4'(c.axis_enable_set[2]) + 4'(c.axis_enable_set[3]);
		if (n == 4'h0) n = 4'h1;
		conv_len = CNT_W'(({20'h0, n} * 24'h32) << c.averaging_select)
			+ (c.self_check_enable ? CNT_W'(24'h64) * (CNT_W'(c.self_check_schedule) + CNT_W'(1))
			: CNT_W'(0));
	endfunction

	// pin sync: only the second and third stages feed logic
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alert_s1_q <= 1'b1;
			alert_s2_q <= 1'b1;
			alert_s3_q <= 1'b1;
		end else if (clk_en) begin
			alert_s1_q <= alert_n_in;
			alert_s2_q <= alert_s1_q;
			alert_s3_q <= alert_s2_q;
		end
	end

	// the pin also carries our own pulse; its echo must not wake or trigger us.
	// limitation: a controller fall that overlaps our pulse is lost
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			own_drive_q <= 3'h0;
		end else if (clk_en) begin
			own_drive_q <= {own_drive_q[1:0], alert_n_oe};
		end
	end
	assign alert_fall = alert_s3_q && !alert_s2_q && (own_drive_q == 3'h0);

	assign trig_hit = (cfg_q.trigger_source == `SPMC_TRIG_SERIAL) ? serial_trigger :
		(cfg_q.trigger_source == `SPMC_TRIG_ALERT) ? alert_fall : 1'b0;

	spmc_delay #(.WIDTH(CNT_W)) spmc_delay_i (
		.clock(clock),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.load(dly_load),
		.count(dly_count),
		.busy(dly_busy),
		.done(dly_done)
	);

	// configuration: deep sleep restores factory values
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cfg_q <= spmc_cfg_type'(`SPMC_CFG_RESET);
		end else if (clk_en) begin
			if (mode_q == `SPMC_MODE_DEEP_SLEEP && state_q == SPMC_SLEEPING) begin
				cfg_q <= spmc_cfg_type'(`SPMC_CFG_RESET);
			end else if (cfg_write && reg_access) begin
				cfg_q <= cfg_in;
			end
		end
	end

	// wake-interval timer in clock cycles, MS_CYC per ms
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wake_cnt_q <= '0;
		end else if (clk_en) begin
			if (state_q != SPMC_SLEEPING || mode_q != `SPMC_MODE_WAKE_SLEEP) begin
				wake_cnt_q <= CNT_W'(MS_CYC) * wake_ms(cfg_q.wake_interval_sel);
			end else if (wake_cnt_q != '0) begin
				wake_cnt_q <= wake_cnt_q - 1'b1;
			end
		end
	end
	assign wake_tick = (state_q == SPMC_SLEEPING) && (mode_q == `SPMC_MODE_WAKE_SLEEP)
		&& (wake_cnt_q == CNT_W'(1));

	// delay loads, combinational from the sequencer
	always_comb begin
		dly_load = 1'b0;
		dly_count = '0;
		case (state_q)
			SPMC_CONFIG: begin
				if (mode_write) begin
					if (mode_select != `SPMC_MODE_CONFIG && mode_select != `SPMC_MODE_SLEEP
						&& mode_select != `SPMC_MODE_DEEP_SLEEP
						&& mode_select != `SPMC_MODE_WAKE_SLEEP) begin
						dly_load = 1'b1;
						dly_count = CNT_W'(STBY_ENTRY_CYC);
					end
				end else if (trig_hit) begin
					dly_load = 1'b1;
					dly_count = CNT_W'(STBY_ENTRY_CYC + STBY_CYC);
				end
			end
			SPMC_STANDBY: begin
				// a mode write wins in the sequencer, so it must not load the timer
				if (!mode_write && mode_q == `SPMC_MODE_ACT_CONT) begin
					dly_load = 1'b1;
					dly_count = CNT_W'(ACT_CYC);
				end else if (!mode_write && trig_hit) begin
					dly_load = 1'b1;
					dly_count = (mode_q == `SPMC_MODE_ACT_TRIG) ? CNT_W'(ACT_CYC)
						: CNT_W'(STBY_CYC);
				end
			end
			SPMC_INIT, SPMC_CONVERT: begin
				if (mode_q == `SPMC_MODE_WAKE_SLEEP && serial_activity) begin
					dly_load = 1'b1;
					dly_count = CNT_W'(SLEEP_EXIT_CYC);
				end
			end
			SPMC_SLEEPING: begin
				if (wake_tick) begin
					dly_load = 1'b1;
					dly_count = CNT_W'(SLEEP_EXIT_CYC + STBY_ENTRY_CYC + STBY_CYC);
				end else if (mode_q != `SPMC_MODE_DEEP_SLEEP
					&& (serial_activity || alert_fall)) begin
					dly_load = 1'b1;
					dly_count = CNT_W'(SLEEP_EXIT_CYC);
				end else if (mode_q == `SPMC_MODE_DEEP_SLEEP && serial_activity) begin
					dly_load = 1'b1;
					dly_count = CNT_W'(SLEEP_EXIT_CYC);
				end
			end
			default: begin
				dly_load = 1'b0;
				dly_count = '0;
			end
		endcase
	end

	// main sequencer
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= SPMC_CONFIG;
			mode_q <= `SPMC_MODE_CONFIG;
			conv_start <= 1'b0;
			conv_cycles <= '0;
		end else if (clk_en) begin
			conv_start <= 1'b0;
			case (state_q)
				SPMC_CONFIG: begin
					if (mode_write) begin
						mode_q <= mode_select;
						if (mode_select == `SPMC_MODE_SLEEP
							|| mode_select == `SPMC_MODE_DEEP_SLEEP
							|| mode_select == `SPMC_MODE_WAKE_SLEEP) begin
							state_q <= SPMC_SLEEPING;
						end else if (mode_select != `SPMC_MODE_CONFIG) begin
							state_q <= SPMC_ENTER_STBY;
						end
					end else if (trig_hit) begin
						state_q <= SPMC_INIT;
					end
				end
				SPMC_ENTER_STBY: begin
					if (dly_done) state_q <= SPMC_STANDBY;
				end
				SPMC_STANDBY: begin
					if (mode_write) begin
						mode_q <= mode_select;
						if (mode_select == `SPMC_MODE_CONFIG) state_q <= SPMC_CONFIG;
						else if (mode_select >= `SPMC_MODE_WAKE_SLEEP) state_q <= SPMC_SLEEPING;
					end else if (dly_load) begin
						state_q <= SPMC_INIT;
					end
				end
				SPMC_INIT: begin
					if (dly_load) begin
						state_q <= SPMC_WAKE_EXIT;
					end else if (dly_done) begin
						conv_start <= 1'b1;
						conv_cycles <= conv_len(cfg_q);
						state_q <= SPMC_CONVERT;
					end
				end
				SPMC_CONVERT: begin
					if (dly_load) begin
						state_q <= SPMC_WAKE_EXIT;
					end else if (conv_done) begin
						if (mode_q == `SPMC_MODE_WAKE_SLEEP) state_q <= SPMC_SLEEPING;
						else if (mode_q == `SPMC_MODE_CONFIG) state_q <= SPMC_CONFIG;
						else state_q <= SPMC_STANDBY;
					end
				end
				SPMC_SLEEPING: begin
					if (wake_tick) begin
						state_q <= SPMC_INIT;
					end else if (dly_load) begin
						state_q <= SPMC_WAKE_EXIT;
					end
				end
				SPMC_WAKE_EXIT: begin
					if (dly_done) begin
						state_q <= SPMC_CONFIG;
						mode_q <= `SPMC_MODE_CONFIG;
					end
				end
				default: state_q <= SPMC_CONFIG;
			endcase
		end
	end

	// status flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			support_on <= 1'b0;
			reg_access <= 1'b1;
			results_clear <= 1'b0;
		end else if (clk_en) begin
			support_on <= (state_q == SPMC_STANDBY) || (state_q == SPMC_INIT)
				|| (state_q == SPMC_CONVERT);
			reg_access <= (state_q == SPMC_CONFIG);
			results_clear <= (state_q == SPMC_SLEEPING)
				&& (mode_q == `SPMC_MODE_DEEP_SLEEP);
		end
	end

	// alert output: pulse on done, or only on threshold
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			alert_n_out <= 1'b1;
			alert_n_oe <= 1'b0;
		end else if (clk_en) begin
			alert_n_out <= 1'b0;
			alert_n_oe <= (state_q == SPMC_CONVERT) && conv_done
				&& (mode_q == `SPMC_MODE_WAKE_SLEEP)
				&& ((cfg_q.alert_select == `SPMC_ALERT_ON_DONE) || thresh_hit);
		end
	end

	// deep sleep must never reach a conversion start
	a_deep_no_conv: assert property (@(posedge clock) disable iff (!rst_n)
		(mode_q == `SPMC_MODE_DEEP_SLEEP) |-> !conv_start)
		else $error("conversion started in deep sleep");
	a_reset_config: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> state_q == SPMC_CONFIG)
		else $error("not in configuration after reset");
	a_exit_config: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == SPMC_WAKE_EXIT && dly_done && clk_en) |=> state_q == SPMC_CONFIG)
		else $error("sleep exit did not reach configuration");
	a_init_start: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == SPMC_INIT && dly_done && !dly_load && clk_en) |=> conv_start)
		else $error("init done without conversion start");
	a_timer_running: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == SPMC_INIT || state_q == SPMC_ENTER_STBY || state_q == SPMC_WAKE_EXIT)
		|-> (dly_busy || dly_done))
		else $error("delay state without running timer");
	a_deep_cfg_clear: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && state_q == SPMC_SLEEPING && mode_q == `SPMC_MODE_DEEP_SLEEP)
		|=> cfg_q == spmc_cfg_type'(`SPMC_CFG_RESET))
		else $error("configuration kept in deep sleep");
	a_standby_pwr: assert property (@(posedge clock) disable iff (!rst_n)
		(state_q == SPMC_STANDBY && clk_en) |=> support_on)
		else $error("support off in standby");
	a_alert_thresh: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && state_q == SPMC_CONVERT && conv_done && !thresh_hit
		&& mode_q == `SPMC_MODE_WAKE_SLEEP && cfg_q.alert_select == `SPMC_ALERT_ON_THRESH)
		|=> !alert_n_oe)
		else $error("alert without threshold");
	a_cfg_access: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && state_q == SPMC_CONFIG) |=> reg_access)
		else $error("register access lost in configuration");
	a_mode_write: assert property (@(posedge clock) disable iff (!rst_n)
		(clk_en && state_q == SPMC_CONFIG && mode_write) |=> mode_q == $past(mode_select))
		else $error("mode write not taken");
endmodule

// file: verif/spmc_engine_model.sv
// Purpose: conversion engine and alert wire as seen from the sequencer
// Assumes: the alert line has a pull-up; either party may pull it low
// Notes: slow answers take the reported conversion length
`timescale 1ns/1ps
module spmc_engine_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// sequencer side
	input wire logic conv_start,
	input wire logic [25:0] conv_cycles,
	input wire logic alert_n_out,
	input wire logic alert_n_oe,
	output logic conv_done,
	output logic thresh_hit,
	// bench controls
	input wire logic slow,
	input wire logic thresh_set,
	input wire logic mcu_alert_n,
	output logic alert_n_wire
);
	int cnt;
	// pull-up wins unless a party pulls low
	assign alert_n_wire = ((alert_n_oe === 1'h1 && alert_n_out === 1'h0) ||
		mcu_alert_n === 1'h0) ? 1'h0 : 1'h1;
	// level only valid beside done, so show the inverse elsewhere
	assign thresh_hit = conv_done ? thresh_set : ~thresh_set;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 0;
			conv_done <= 1'h0;
		end else begin
			conv_done <= (cnt == 1);
			if (conv_start)
				cnt <= slow ? int'(conv_cycles) : 4;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule

// file: verif/spmc_top_bench.sv
// Purpose: self-checking bench for the sensor power-mode sequencer
// Assumes: short entry, exit and millisecond counts set below
// Notes: inputs change on the falling clock edge; each scenario starts from reset
`timescale 1ns/1ps
`include "spmc_defs.svh"
module spmc_top_bench import spmc_pkg::*;;
	localparam int SE = 20;
	localparam int SX = 30;
	localparam int AI = `SPMC_ACT_INIT_CYC;
	localparam int SI = `SPMC_STBY_INIT_CYC;
	logic clock = 0, rst_n = 0, mode_write = 0, cfg_write = 0, serial_activity = 0;
	logic serial_trigger = 0, mcu_alert_n = 1, slow = 0, thresh_set = 0;
	logic alert_n_wire, alert_n_out, alert_n_oe, conv_done, thresh_hit, conv_start;
	logic results_clear, support_on, reg_access;
	logic clk_en = 1'h1;
	logic [2:0] mode_select = 0;
	logic [2:0] mode_q;
	logic [25:0] conv_cycles;
	spmc_cfg_type cfg_in = '0;
	spmc_cfg_type cfg_q, c;
	int err_count = 0, cmp_count = 0, starts = 0, dones = 0, pulses = 0, n, s0, d0, p0;

	always #12.5 clock = ~clock;

	always @(posedge clock) begin
		if (conv_start === 1'h1) starts++;
		if (conv_done === 1'h1) dones++;
		if (alert_n_oe === 1'h1 && alert_n_wire === 1'h0) pulses++;
	end

	spmc_top #(.STBY_ENTRY_CYC(SE), .SLEEP_EXIT_CYC(SX), .MS_CYC(10)) spmc_top_i (
		.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .mode_select(mode_select),
		.mode_write(mode_write), .cfg_in(cfg_in), .cfg_write(cfg_write),
		.serial_activity(serial_activity), .serial_trigger(serial_trigger),
		.alert_n_in(alert_n_wire), .alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe),
		.conv_done(conv_done), .thresh_hit(thresh_hit), .conv_start(conv_start),
		.conv_cycles(conv_cycles), .results_clear(results_clear), .mode_q(mode_q),
		.support_on(support_on), .reg_access(reg_access), .cfg_q(cfg_q));

	spmc_engine_model spmc_engine_model_i (
		.clock(clock), .rst_n(rst_n), .conv_start(conv_start), .conv_cycles(conv_cycles),
		.alert_n_out(alert_n_out), .alert_n_oe(alert_n_oe), .conv_done(conv_done),
		.thresh_hit(thresh_hit), .slow(slow), .thresh_set(thresh_set),
		.mcu_alert_n(mcu_alert_n), .alert_n_wire(alert_n_wire));

	task chk(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// a value inside the window reports as the low bound
	task rng(int v, int lo, int hi);
		chk((v >= lo && v <= hi) ? lo : v, lo);
	endtask

	task finish_test;
		$display("errors %0d, comparisons %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task cyc(int k);
		repeat (k) @(negedge clock);
	endtask

	task automatic pul(ref logic s);
		s = 1'h1;
		cyc(1);
		s = 1'h0;
	endtask

	// held two cycles so the three-flop synchroniser sees the fall
	task alr;
		mcu_alert_n = 1'h0;
		cyc(2);
		mcu_alert_n = 1'h1;
	endtask

	task setm(logic [2:0] m);
		mode_select = m;
		pul(mode_write);
	endtask

	task wst(int lim);
		n = 0;
		while (conv_start !== 1'h1 && n < lim) begin
			cyc(1);
			n++;
		end
	endtask

	task go(spmc_cfg_type v);
		rst_n = 1'h0;
		cyc(16);
		rst_n = 1'h1;
		cyc(1);
		cfg_in = v;
		pul(cfg_write);
		cyc(1);
	endtask

	function automatic spmc_cfg_type mk(logic [1:0] src, logic asel);
		spmc_cfg_type v;
		v = '0;
		v.axis_enable_set = 4'h3;
		v.averaging_select = 3'h1;
		v.trigger_source = src;
		v.alert_select = asel;
		return v;
	endfunction

	initial begin
		cyc(60000);
		err_count++;
		finish_test();
	end

	initial begin
		c = mk(2'h0, 1'h0);
		go(c);
		chk(mode_q, `SPMC_MODE_CONFIG);
		chk(reg_access, 1);
		chk(alert_n_oe, 0);
		chk(cfg_q, c);
		// a frozen clock enable must swallow a mode write
		clk_en = 1'h0;
		setm(`SPMC_MODE_STANDBY);
		cyc(2);
		clk_en = 1'h1;
		chk(mode_q, `SPMC_MODE_CONFIG);
		pul(serial_trigger);
		wst(SE + SI + 40);
		rng(n, SE + SI - 4, SE + SI + 12);
		chk(conv_cycles, 32'hC8);
		// wrong trigger source first, then the selected one
		for (int s = 0; s < 2; s++) begin
			go(mk(s[1:0], 1'h0));
			setm(`SPMC_MODE_STANDBY);
			cyc(SE + 8);
			chk(mode_q, `SPMC_MODE_STANDBY);
			chk(support_on, 1);
			chk(reg_access, 0);
			cfg_in = '1;
			pul(cfg_write);
			chk(cfg_q, mk(s[1:0], 1'h0));
			if (s == 0) alr(); else pul(serial_trigger);
			wst(SI + 40);
			chk(n, SI + 40);
			if (s == 0) pul(serial_trigger); else alr();
			wst(SI + 40);
			rng(n, SI - 4, SI + 12);
		end
		slow = 1'h1;
		for (int m = 2; m < 4; m++) begin
			go(mk(2'h0, 1'h0));
			setm(m[2:0]);
			wst(SE + AI + 60);
			if (m == 3) begin
				chk(n, SE + AI + 60);
				pul(serial_trigger);
				wst(SI + 40);
			end
			rng(n, m == 2 ? SE + AI - 4 : AI - 4, m == 2 ? SE + AI + 12 : AI + 12);
			// the start just seen is counted at the next rising edge
			s0 = starts + 1;
			cyc(1000);
			rng(starts - s0, 3 - m, 99 * (3 - m));
		end
		slow = 1'h0;
		for (int s = 0; s < 2; s++) begin
			c = mk(2'h0, s[0]);
			go(c);
			setm(`SPMC_MODE_SLEEP);
			cyc(8);
			chk(mode_q, `SPMC_MODE_SLEEP);
			chk(results_clear, 0);
			if (s == 0) pul(serial_activity); else alr();
			cyc(SX + 12);
			chk(mode_q, `SPMC_MODE_CONFIG);
			chk(cfg_q, c);
		end
		// pulse per conversion, then threshold only without and with a hit
		for (int s = 0; s < 3; s++) begin
			go(mk(2'h0, s != 0));
			thresh_set = (s == 2);
			d0 = dones;
			p0 = pulses;
			setm(`SPMC_MODE_WAKE_SLEEP);
			cyc(4000);
			rng(dones - d0, 1, 4);
			if (s == 1) chk(pulses - p0, 0);
			else rng(pulses - p0, dones - d0 - 1, dones - d0);
			pul(serial_activity);
			cyc(SX + SI + 100);
			chk(mode_q, `SPMC_MODE_CONFIG);
		end
		go(mk(2'h1, 1'h1));
		setm(`SPMC_MODE_DEEP_SLEEP);
		cyc(8);
		chk(results_clear, 1);
		chk(cfg_q, 0);
		s0 = starts;
		pul(serial_trigger);
		alr();
		cyc(SI + 100);
		chk(starts - s0, 0);
		pul(serial_activity);
		cyc(SX + 12);
		chk(mode_q, `SPMC_MODE_CONFIG);
		finish_test();
	end
endmodule
